// >>> verilog/vch_defines.svh
// Constants of the voltage command handler: characters, positions, lengths
`ifndef VCH_DEFINES_SVH
`define VCH_DEFINES_SVH

// ==================================================================
// Buffer sizes
`define VCH_LINE_LEN 20
`define VCH_RESP_LEN 32
`define VCH_LEN_OVER 5'h1f

// ==================================================================
// Characters
`define VCH_CH_START 8'h3e
`define VCH_CH_CR 8'h0d
`define VCH_CH_LF 8'h0a
`define VCH_CH_SPACE 8'h20
`define VCH_CH_ZERO 8'h30
`define VCH_CH_CASE 8'h20

// ==================================================================
// Field positions within a command line
`define VCH_POS_ID 5
`define VCH_POS_ID_RAIL 4
`define VCH_POS_SEP1 7
`define VCH_POS_VAL1 8
`define VCH_POS_SEP_HEX 12
`define VCH_POS_HEX2 13
`define VCH_POS_SEP_VOLT 13
`define VCH_POS_VOLT2 14

// ==================================================================
// Command line lengths, start character included
`define VCH_LEN_CLK_HEX 5'h11
`define VCH_LEN_CLK_VOLT 5'h13
`define VCH_LEN_BIAS_HEX 5'h0c
`define VCH_LEN_BIAS_VOLT 5'h0d
`define VCH_LEN_READ 5'h07
`define VCH_LEN_RAIL 5'h06

// ==================================================================
// Highest identifier index per voltage group, last connected bias and bias gap ends
`define VCH_ID_MAX_CLK 4'hf
`define VCH_ID_MAX_BIAS 4'hb
`define VCH_ID_MAX_PWR 4'h9
`define VCH_ID_MAX_TEMP 4'h2
`define VCH_BIAS_LAST 4'ha
`define VCH_BIAS_GAP_FROM 4'h2
`define VCH_BIAS_GAP_TO 4'h5

// ==================================================================
// Reply lengths and voltage limit in tenths
`define VCH_RLEN_BIAS 6'h20
`define VCH_RLEN_PWR 6'h1a
`define VCH_RLEN_TEMP 6'h1b
`define VCH_RLEN_OK 6'h04
`define VCH_RLEN_ERR 6'h05
`define VCH_TENTHS_MAX 10'h3e7

`endif

// >>> verilog/vch_pkg.sv
// Types shared by the voltage command handler modules
`default_nettype none
`include "vch_defines.svh"

package vch_pkg;

  typedef logic [`VCH_LINE_LEN-1:0][7:0] vch_line_type;
  typedef logic [`VCH_RESP_LEN-1:0][7:0] vch_resp_type;

  typedef enum logic [1:0] {GRP_BIAS, GRP_POWER, GRP_TEMP} vch_group_type;

  typedef enum logic [2:0] {
    REPLY_OK, REPLY_ERR, REPLY_BIAS, REPLY_POWER, REPLY_TEMP
  } vch_reply_type;

  // Output setting; in volts the values are signed tenths of a volt
  typedef struct packed {
    logic clock_rail;
    logic set_b;
    logic in_volts;
    logic [3:0] id;
    logic [15:0] high;
    logic [15:0] low;
  } vch_dac_wr_type;

  typedef struct packed {
    vch_group_type group;
    logic set_b;
    logic [3:0] id;
  } vch_meas_req_type;

  typedef struct packed {
    logic [11:0] dac;
    logic [11:0] adc;
    logic signed [10:0] tenths;
  } vch_meas_resp_type;

endpackage : vch_pkg

`default_nettype wire

// >>> verilog/vch_line_rx.sv
// Collects received characters into one command line
`default_nettype none
`include "vch_defines.svh"

module vch_line_rx (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  output logic rx_ready,
  output logic line_valid,
  output var vch_pkg::vch_line_type line,
  output logic [4:0] line_len,
  input wire logic line_take
);
  import vch_pkg::*;

  // ================================================================
  // Character classes
  wire take_char = rx_valid && rx_ready;
  wire is_cr = rx_char == `VCH_CH_CR;
  wire is_lf = rx_char == `VCH_CH_LF;
  wire room = line_len < 5'(`VCH_LINE_LEN);
  wire store = take_char && !is_cr && !is_lf && room;
  wire over = line_len == `VCH_LEN_OVER;

  // Line held until taken
  assign rx_ready = !line_valid;

  // ================================================================
  // Line store
  always_ff @(posedge clock) begin
    if (sys_rst || line_take) begin
      line_valid <= 1'b0;
      line_len <= 5'h00;
      line <= '0;
    end else if (take_char && is_cr) begin
      line_valid <= 1'b1;
    end else if (take_char && !is_lf) begin
      if (store) begin
        line[line_len] <= rx_char;
      end
      if (!over) begin
        line_len <= line_len + 5'h01;
      end
    end
  end

endmodule : vch_line_rx

`default_nettype wire

// >>> verilog/vch_tx_fmt.sv
// Sends one formatted reply text, first character first
`default_nettype none
`include "vch_defines.svh"

module vch_tx_fmt (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic send_start,
  input wire vch_pkg::vch_resp_type send_text,
  input wire logic [5:0] send_len,
  output logic send_busy,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_char
);
  import vch_pkg::*;

  vch_resp_type text;
  logic [5:0] left;

  // ================================================================
  // Character stream
  assign tx_valid = send_busy;
  assign tx_char = text[`VCH_RESP_LEN-1];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      send_busy <= 1'b0;
      text <= '0;
      left <= 6'h00;
    end else if (send_start && !send_busy) begin
      text <= send_text;
      left <= send_len;
      send_busy <= send_len != 6'h00;
    end else if (send_busy && tx_ready) begin
      text <= {text[`VCH_RESP_LEN-2:0], 8'h00};
      left <= left - 6'h01;
      send_busy <= left != 6'h01;
    end
  end

endmodule : vch_tx_fmt

`default_nettype wire

// >>> verilog/vch_handler.sv
// Voltage command handler: parses voltage commands and formats replies
//
// Summary of operation
// RL1: Commands start with greater-than, ASCII parameters.
// RL2: Clock voltage access stops the detector clocks.
// RL3: Two-digit identifier follows command, set chosen.
// RL4: Clock hex write: high then low value.
// RL5: Hex values carry a leading zero digit.
// RL6: Volts: sign, two digits, point, digit.
// RL7: Single spaces separate clock volts fields.
// RL8: Accepted writes answer OK.
// RL9: Bias identifiers 00 to b0, step 10.
// RL10: Bias read: tag, id, name, dac, adc, volts.
// RL11: Echoed identifier equals the one sent.
// RL12: Bias setting shown as four hex, zero first.
// RL13: Measured value left-justified, last digit zero.
// RL14: Volts shown signed, zero filled, trailing v.
// RL15: Identifier ff returns all nine connected biases.
// RL16: Bias hex write carries one hex value.
// RL17: Bias volts write: one space, one value.
// RL18: Power rail read identifiers 00 to 90.
// RL19: Power read: tag, id, name, adc, volts.
// RL20: Board rail read identifiers 00, 10, 20.
// RL21: Board rail read: tag, id, name, adc, volts.
// RL22: Voltage names are fixed labels.
// RL23: Setting applied only after whole command checked.
`default_nettype none
`include "vch_defines.svh"

module vch_handler (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  output logic rx_ready,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_char,
  output logic dac_wr_valid,
  output var vch_pkg::vch_dac_wr_type dac_wr,
  output logic meas_req_valid,
  output var vch_pkg::vch_meas_req_type meas_req,
  input wire logic meas_ack,
  input wire vch_pkg::vch_meas_resp_type meas_resp,
  output logic clocks_stopped,
  input wire logic clocks_restart
);
  import vch_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_MEAS_REQ, ST_MEAS_WAIT, ST_LOAD, ST_SEND
  } vch_state_type;

  // ================================================================
  // Character helpers
  function automatic logic is_dig(input logic [7:0] c);
    return c >= "0" && c <= "9";
  endfunction : is_dig

  function automatic logic hex_ok(input logic [7:0] c);
    logic [7:0] l;
    l = c | `VCH_CH_CASE;
    return is_dig(c) || (l >= "a" && l <= "f");
  endfunction : hex_ok

  function automatic logic [3:0] hex_nib(input logic [7:0] c);
    logic [7:0] l;
    l = c | `VCH_CH_CASE;
    return is_dig(c) ? 4'(c - "0") : 4'(l - "a" + 8'h0a);
  endfunction : hex_nib

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'ha) ? 8'("0" + {4'h0, n}) : 8'("A" - 8'h0a + {4'h0, n});
  endfunction : hex_chr

  function automatic logic [31:0] hex4(input logic [15:0] v);
    return {hex_chr(v[15:12]), hex_chr(v[11:8]),
            hex_chr(v[7:4]), hex_chr(v[3:0])};
  endfunction : hex4

  // Four hex digits, first one zero
  function automatic logic hex_word_ok(input vch_line_type ln, input int p);
    return ln[p] == `VCH_CH_ZERO && hex_ok(ln[p+1]) && // RL5
           hex_ok(ln[p+2]) && hex_ok(ln[p+3]);
  endfunction : hex_word_ok

  function automatic logic [15:0] hex_word(input vch_line_type ln,
                                           input int p);
    return {4'h0, hex_nib(ln[p+1]), hex_nib(ln[p+2]), hex_nib(ln[p+3])};
  endfunction : hex_word

  // Sign, two digits, point, one digit
  function automatic logic volt_ok(input vch_line_type ln, input int p);
    return (ln[p] == "+" || ln[p] == "-") && is_dig(ln[p+1]) && // RL6
           is_dig(ln[p+2]) && ln[p+3] == "." && is_dig(ln[p+4]);
  endfunction : volt_ok

  function automatic logic [15:0] volt_val(input vch_line_type ln,
                                           input int p);
    logic [15:0] m;
    m = 16'(ln[p+1] - "0") * 16'h0064 + 16'(ln[p+2] - "0") * 16'h000a +
        16'(ln[p+4] - "0");
    return (ln[p] == "-") ? 16'(-m) : m;
  endfunction : volt_val

  function automatic logic [7:0] dig(input logic [9:0] d);
    return 8'("0" + 8'(d));
  endfunction : dig

  function automatic logic [47:0] volt_text(input logic signed [10:0] t);
    logic [10:0] a;
    logic [9:0] m;
    a = t[10] ? 11'(-t) : t;
    m = (a > 11'(`VCH_TENTHS_MAX)) ? `VCH_TENTHS_MAX : a[9:0];
    return {t[10] ? "-" : "+", dig(m / 10'd100), dig((m / 10'd10) % 10'd10),
            ".", dig(m % 10'd10), "v"}; // RL14
  endfunction : volt_text

  // Fixed label per voltage; nothing writes these
  function automatic logic [31:0] name_text(input vch_group_type g,
                                            input logic [3:0] n);
    logic [31:0] s;
    s = "----";
    unique case (g)
      GRP_BIAS: begin
        unique case (n)
          4'h0: s = "NADA";
          4'h1: s = "NADB";
          4'h2: s = "NRD ";
          4'h4: s = "VOFS";
          4'h5: s = "NSUB";
          4'h6: s = "OG  ";
          4'h7: s = "NEGS";
          4'h8: s = "PADA";
          4'h9: s = "PADB";
          4'ha: s = "PRD ";
          default: s = "NC  ";
        endcase
      end
      GRP_POWER: begin
        unique case (n)
          4'h0: s = "+48V";
          4'h1: s = "+30V";
          4'h2: s = "+15V";
          4'h3: s = "+5V ";
          4'h4: s = "-5V ";
          4'h5: s = "-15V";
          4'h6: s = "-30V";
          4'h7: s = "+12V";
          4'h8: s = "-12V";
          default: s = "VCC ";
        endcase
      end
      default: begin
        unique case (n)
          4'h0: s = "+15B";
          4'h1: s = "-15B";
          default: s = "+5VB";
        endcase
      end
    endcase
    return s; // RL22
  endfunction : name_text

  // Next connected bias output, skipping the two without a pin
  function automatic logic [3:0] next_conn(input logic [3:0] n);
    return (n == `VCH_BIAS_GAP_FROM) ? `VCH_BIAS_GAP_TO : n + 4'h1; // RL15
  endfunction : next_conn

  // ================================================================
  // Line receiver and reply sender
  vch_line_type line;
  logic [4:0] line_len;
  logic line_valid;
  logic send_busy;
  vch_state_type state;
  vch_reply_type reply;
  vch_meas_resp_type meas;
  logic all_mode;
  vch_resp_type resp_text;
  logic [5:0] resp_len;

  wire line_take = state == ST_IDLE && line_valid;
  wire send_start = state == ST_LOAD;

  vch_line_rx u_line_rx (
    .clock(clock),
    .sys_rst(sys_rst),
    .rx_valid(rx_valid),
    .rx_char(rx_char),
    .rx_ready(rx_ready),
    .line_valid(line_valid),
    .line(line),
    .line_len(line_len),
    .line_take(line_take)
  );

  vch_tx_fmt u_tx_fmt (
    .clock(clock),
    .sys_rst(sys_rst),
    .send_start(send_start),
    .send_text(resp_text),
    .send_len(resp_len),
    .send_busy(send_busy),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .tx_char(tx_char)
  );

  // ================================================================
  // Command decode
  wire [7:0] c1 = line[1];
  wire [7:0] c2 = line[2];
  wire [7:0] c3 = line[3];
  wire [7:0] c4 = line[4];
  wire start_ok = line[0] == `VCH_CH_START; // RL1
  wire volts = c2 == "D";
  wire set_ab = c4 == "A" || c4 == "B";
  wire set_01 = c4 == "0" || c4 == "1";
  wire set_b = c4 == "B" || c4 == "1";
  wire write_op = start_ok && c1 == "W" && (c2 == "V" || volts);
  wire clk_cmd = write_op && c3 == "C" && set_ab;
  wire bias_w_cmd = write_op && c3 == "B" && set_01;
  wire read_op = start_ok && c1 == "R" && c2 == "V";
  wire bias_r_cmd = read_op && c3 == "B" && set_01 &&
                    line_len == `VCH_LEN_READ;
  wire temp_cmd = read_op && c3 == "P" && c4 == "B" &&
                  line_len == `VCH_LEN_READ; // RL20
  wire pwr_cmd = read_op && c3 == "P" && line_len == `VCH_LEN_RAIL; // RL18

  // Identifier right after the command letters
  wire [7:0] id_hc = pwr_cmd ? line[`VCH_POS_ID_RAIL] : line[`VCH_POS_ID];
  wire [7:0] id_lc = pwr_cmd ? line[`VCH_POS_ID] : line[`VCH_POS_ID+1];
  wire [3:0] id_n = hex_nib(id_hc); // RL3
  wire id_form = hex_ok(id_hc) && id_lc == `VCH_CH_ZERO;
  wire id_all = (id_hc | `VCH_CH_CASE) == "f" &&
                (id_lc | `VCH_CH_CASE) == "f";
  wire [3:0] id_max = clk_cmd ? `VCH_ID_MAX_CLK :
                      pwr_cmd ? `VCH_ID_MAX_PWR :
                      temp_cmd ? `VCH_ID_MAX_TEMP :
                      `VCH_ID_MAX_BIAS; // RL9
  wire id_ok = id_form && id_n <= id_max;

  // Whole-line format checks
  wire sep1 = line[`VCH_POS_SEP1] == `VCH_CH_SPACE;
  wire clk_hex_ok = clk_cmd && !volts && line_len == `VCH_LEN_CLK_HEX &&
                    sep1 && line[`VCH_POS_SEP_HEX] == `VCH_CH_SPACE &&
                    hex_word_ok(line, `VCH_POS_VAL1) &&
                    hex_word_ok(line, `VCH_POS_HEX2); // RL4
  wire clk_volt_ok = clk_cmd && volts && line_len == `VCH_LEN_CLK_VOLT &&
                     sep1 && line[`VCH_POS_SEP_VOLT] == `VCH_CH_SPACE &&
                     volt_ok(line, `VCH_POS_VAL1) &&
                     volt_ok(line, `VCH_POS_VOLT2); // RL7
  wire bias_hex_ok = bias_w_cmd && !volts &&
                     line_len == `VCH_LEN_BIAS_HEX && sep1 &&
                     hex_word_ok(line, `VCH_POS_VAL1); // RL16
  wire bias_volt_ok = bias_w_cmd && volts &&
                      line_len == `VCH_LEN_BIAS_VOLT && sep1 &&
                      volt_ok(line, `VCH_POS_VAL1); // RL17
  wire clk_wr_ok = id_ok && (clk_hex_ok || clk_volt_ok);
  wire wr_ok = clk_wr_ok || (id_ok && (bias_hex_ok || bias_volt_ok));
  wire rd_ok = (bias_r_cmd && (id_ok || id_all)) ||
               ((pwr_cmd || temp_cmd) && id_ok);

  // Setting and measurement request built from the line
  wire [15:0] val1 = volts ? volt_val(line, `VCH_POS_VAL1) :
                     hex_word(line, `VCH_POS_VAL1);
  wire [15:0] val2 = volts ? volt_val(line, `VCH_POS_VOLT2) :
                     hex_word(line, `VCH_POS_HEX2);
  wire vch_dac_wr_type next_dac = '{
    clock_rail: clk_cmd, set_b: set_b, in_volts: volts, id: id_n,
    high: val1, low: clk_cmd ? val2 : 16'h0000};
  wire vch_group_type next_group = pwr_cmd ? GRP_POWER :
                                   temp_cmd ? GRP_TEMP : GRP_BIAS;
  wire vch_meas_req_type next_req = '{
    group: next_group, set_b: set_b, id: id_all ? 4'h0 : id_n};
  wire vch_reply_type meas_reply = (meas_req.group == GRP_POWER) ?
                                   REPLY_POWER :
                                   (meas_req.group == GRP_TEMP) ?
                                   REPLY_TEMP : REPLY_BIAS;

  // ================================================================
  // Reply texts
  wire [7:0] id_ch = hex_chr(meas_req.id); // RL11
  wire [7:0] set_ch = meas_req.set_b ? "1" : "0";
  wire [31:0] name = name_text(meas_req.group, meas_req.id);
  wire [31:0] dac_txt = hex4({4'h0, meas.dac}); // RL12
  wire [31:0] adc_txt = hex4({meas.adc, 4'h0}); // RL13
  wire [47:0] v_txt = volt_text(meas.tenths);
  wire [15:0] eol = {`VCH_CH_CR, `VCH_CH_LF};
  wire [255:0] bias_txt = {"_RVB", set_ch, " ", id_ch, "0", " ", name,
                           " ", dac_txt, " ", adc_txt, " ", v_txt,
                           eol}; // RL10
  wire [207:0] pwr_txt = {"_R", "VP", " ", id_ch, "0", " ", name, " ",
                          adc_txt, " ", v_txt, eol}; // RL19
  wire [215:0] temp_txt = {"_R", "VPB", " ", id_ch, "0", " ", name, " ",
                           adc_txt, " ", v_txt, eol}; // RL21

  assign resp_text = (reply == REPLY_BIAS) ? bias_txt :
                     (reply == REPLY_POWER) ? {pwr_txt, 48'h0} :
                     (reply == REPLY_TEMP) ? {temp_txt, 40'h0} :
                     (reply == REPLY_OK) ? {"OK", eol, 224'h0} : // RL8
                     {"ERR", eol, 216'h0};
  assign resp_len = (reply == REPLY_BIAS) ? `VCH_RLEN_BIAS :
                    (reply == REPLY_POWER) ? `VCH_RLEN_PWR :
                    (reply == REPLY_TEMP) ? `VCH_RLEN_TEMP :
                    (reply == REPLY_OK) ? `VCH_RLEN_OK : `VCH_RLEN_ERR;

  assign meas_req_valid = state == ST_MEAS_REQ;

  // ================================================================
  // Clock halt: set by a clock write, set wins over restart
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clocks_stopped <= 1'b0;
    end else if (line_take && clk_wr_ok) begin
      clocks_stopped <= 1'b1; // RL2
    end else if (clocks_restart) begin
      clocks_stopped <= 1'b0;
    end
  end

  // ================================================================
  // Sequencer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      reply <= REPLY_OK;
      dac_wr_valid <= 1'b0;
      dac_wr <= '0;
      meas_req <= '0;
      meas <= '0;
      all_mode <= 1'b0;
    end else begin
      dac_wr_valid <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (line_valid && wr_ok) begin
            dac_wr <= next_dac; // RL23
            dac_wr_valid <= 1'b1;
            reply <= REPLY_OK;
            state <= ST_LOAD;
          end else if (line_valid && rd_ok) begin
            meas_req <= next_req;
            all_mode <= bias_r_cmd && id_all; // RL15
            state <= ST_MEAS_REQ;
          end else if (line_valid) begin
            reply <= REPLY_ERR;
            state <= ST_LOAD;
          end
        end
        ST_MEAS_REQ: begin
          state <= ST_MEAS_WAIT;
        end
        ST_MEAS_WAIT: begin
          if (meas_ack) begin
            meas <= meas_resp;
            reply <= meas_reply;
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          state <= ST_SEND;
        end
        ST_SEND: begin
          if (!send_busy && all_mode && meas_req.id != `VCH_BIAS_LAST) begin
            meas_req.id <= next_conn(meas_req.id); // RL15
            state <= ST_MEAS_REQ;
          end else if (!send_busy) begin
            all_mode <= 1'b0;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule : vch_handler

`default_nettype wire

// >>> test/vch_handler_monitor.sv
// Port checker of the voltage command handler
`default_nettype none
module vch_mon
  import vch_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_char,
  input wire logic dac_wr_valid,
  input wire vch_pkg::vch_dac_wr_type dac_wr,
  input wire logic meas_req_valid,
  input wire vch_pkg::vch_meas_req_type meas_req,
  input wire logic meas_ack,
  input wire vch_pkg::vch_meas_resp_type meas_resp,
  input wire logic clocks_stopped,
  input wire logic clocks_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence cr_taken;
    rx_valid && rx_ready && rx_char == 8'h0d;
  endsequence
  sequence ok_start;
    tx_valid && tx_char == 8'h4f;
  endsequence
  line_hold_a: assert property (cr_taken |=> !rx_ready)
    else $error("line end not held");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_char))
    else $error("reply char changed before taken");
  ok_reply_a: assert property (dac_wr_valid |-> ##[1:2] ok_start)
    else $error("write not answered with OK");
  write_pulse_a: assert property (dac_wr_valid |=>
    !dac_wr_valid && $stable(dac_wr))
    else $error("write pulse too long");
  hex_lead_a: assert property (dac_wr_valid && !dac_wr.in_volts |->
    dac_wr.high[15:12] == 4'h0 && dac_wr.low[15:12] == 4'h0)
    else $error("hex setting above fff");
  clk_stop_a: assert property (dac_wr_valid && dac_wr.clock_rail |=>
    clocks_stopped)
    else $error("clocks not stopped");
  clk_run_a: assert property ($fell(clocks_stopped) |->
    $past(clocks_restart))
    else $error("clocks restarted unasked");
  req_pulse_a: assert property (meas_req_valid |=> !meas_req_valid)
    else $error("request pulse too long");
  req_hold_a: assert property (meas_req_valid ##1 !meas_req_valid |->
    $stable(meas_req))
    else $error("request changed while waiting");
  board_id_a: assert property (meas_req_valid &&
    meas_req.group == GRP_TEMP |-> meas_req.id <= 4'h2)
    else $error("board rail id out of range");
endmodule : vch_mon

bind vch_handler vch_mon i_mon (
  .clock(clock), .sys_rst(sys_rst), .rx_valid(rx_valid),
  .rx_char(rx_char), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_char(tx_char), .dac_wr_valid(dac_wr_valid),
  .dac_wr(dac_wr), .meas_req_valid(meas_req_valid), .meas_req(meas_req),
  .meas_ack(meas_ack), .meas_resp(meas_resp),
  .clocks_stopped(clocks_stopped), .clocks_restart(clocks_restart)
);
`default_nettype wire

// >>> test/vch_afe_model.sv
// Converter front end model answering settings and measurements
`default_nettype none
module vch_afe_model
  import vch_pkg::*;
(
  input wire logic clock,
  input wire logic dac_wr_valid,
  input wire vch_pkg::vch_dac_wr_type dac_wr,
  input wire logic meas_req_valid,
  input wire vch_pkg::vch_meas_req_type meas_req,
  output logic meas_ack,
  output var vch_pkg::vch_meas_resp_type meas_resp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Store and answer
  logic [11:0] store [32] = '{default: 12'h000};
  int wait_cnt = 0;
  initial meas_ack = 1'b0;
  initial meas_resp = '0;
  always @(posedge clock) begin
    if (dac_wr_valid && !dac_wr.clock_rail && !dac_wr.in_volts) begin
      store[{dac_wr.set_b, dac_wr.id}] <= dac_wr.high[11:0];
    end
    if (meas_req_valid) begin
      wait_cnt <= 1 + $urandom_range(3);
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
    meas_ack <= (wait_cnt == 1) && !meas_req_valid;
    // Answer data scrambled outside the acknowledge cycle
    if (wait_cnt == 1) begin
      meas_resp.dac <= store[{meas_req.set_b, meas_req.id}];
      meas_resp.adc <= 12'($urandom);
      meas_resp.tenths <= 11'($urandom);
    end else begin
      meas_resp <= ~meas_resp;
    end
  end
endmodule : vch_afe_model
`default_nettype wire

// >>> test/test_vch_handler.sv
// Self-checking bench of the voltage command handler
`default_nettype none
module test_vch_handler
  import vch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Signals and capture
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic rx_valid = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic tx_ready = 1'b0;
  logic clocks_restart = 1'b0;
  logic rx_ready, tx_valid, dac_wr_valid, meas_req_valid, meas_ack;
  logic clocks_stopped;
  logic [7:0] tx_char;
  vch_dac_wr_type dac_wr;
  vch_meas_req_type meas_req;
  vch_meas_resp_type meas_resp;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] txq[$];
  vch_dac_wr_type wr_q[$];
  vch_meas_resp_type rsp_q[$];
  logic [3:0] id_q[$];
  logic [11:0] v;
  string id;
  string tag;
  always #5 clock = ~clock;
  vch_handler i_dut (.clock(clock), .sys_rst(sys_rst), .rx_valid(rx_valid),
    .rx_char(rx_char), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_char(tx_char), .dac_wr_valid(dac_wr_valid),
    .dac_wr(dac_wr), .meas_req_valid(meas_req_valid),
    .meas_req(meas_req), .meas_ack(meas_ack), .meas_resp(meas_resp),
    .clocks_stopped(clocks_stopped), .clocks_restart(clocks_restart));
  vch_afe_model i_afe (.clock(clock), .dac_wr_valid(dac_wr_valid),
    .dac_wr(dac_wr), .meas_req_valid(meas_req_valid),
    .meas_req(meas_req), .meas_ack(meas_ack), .meas_resp(meas_resp));
  always @(posedge clock) begin
    if (tx_valid && tx_ready) txq.push_back(tx_char);
    if (dac_wr_valid) wr_q.push_back(dac_wr);
    if (meas_ack) rsp_q.push_back(meas_resp);
    if (meas_req_valid) id_q.push_back(meas_req.id);
    tx_ready <= 1'($urandom_range(1));
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ==========
  // Tasks and model
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic string hx(input logic [11:0] x);
    string s;
    s = $sformatf("%h", x);
    return s.toupper();
  endfunction : hx
  function automatic string volts(input logic signed [10:0] t);
    int m;
    m = (t < 0) ? -int'(t) : int'(t);
    if (m > 999) m = 999;
    return $sformatf("%s%02d.%0dv", (t < 0) ? "-" : "+", m / 10, m % 10);
  endfunction : volts
  task automatic send(input string s);
    s = {">", s, "\r"};
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_char <= s[i];
      do @(posedge clock); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
  endtask : send
  task automatic expect_txt(input string e);
    logic [7:0] b;
    while (txq.size() < e.len()) @(posedge clock);
    for (int i = 0; i < e.len(); i++) begin
      b = txq.pop_front();
      if (e[i] != "?") chk(b, e[i]);
    end
  endtask : expect_txt
  task automatic wr(input string s, input vch_dac_wr_type exp);
    send(s);
    expect_txt("OK\r\n");
    chk(wr_q.pop_front(), exp);
    $display("write %s done", s);
  endtask : wr
  task automatic rd_one(input string tag, input string nn, input bit bias);
    vch_meas_resp_type r;
    string d;
    while (rsp_q.size() == 0) @(posedge clock);
    r = rsp_q.pop_front();
    chk(id_q.pop_front(), nn.atohex() >> 4);
    d = bias ? {"0", hx(r.dac), " "} : "";
    expect_txt({tag, nn, " ???? ", d, hx(r.adc), "0 ", volts(r.tenths),
      "\r\n"});
  endtask : rd_one
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'h0f5f));
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    chk(clocks_stopped, 0);
    v = 12'($urandom);
    wr({"W", "VB060 0", hx(v)}, {3'b000, 4'h6, 16'(v), 16'h0});
    send({"R", "VB060"});
    rd_one({"_R", "VB0 "}, "60", 1'b1);
    $display("bias read done");
    wr({"W", "VCB20 0C00 03FF"}, {3'b110, 4'h2, 16'h0c00, 16'h03ff});
    chk(clocks_stopped, 1);
    clocks_restart <= 1'b1;
    @(posedge clock);
    clocks_restart <= 1'b0;
    @(posedge clock);
    chk(clocks_stopped, 0);
    wr({"W", "DCA20 +05.0 -05.0"}, {3'b101, 4'h2, 16'd50, -16'sd50});
    wr({"W", "DB1A0 +08.2"}, {3'b011, 4'ha, 16'd82, 16'h0});
    send({"W", "VB060 1123"});
    expect_txt("ERR\r\n");
    chk(wr_q.size(), 0);
    $display("refused write done");
    for (int i = 0; i < 13; i++) begin
      id = $sformatf("%0d0", i % 10);
      tag = "VPB";
      if (i < 10) tag = "VP";
      send({"R", tag, id});
      rd_one({"_R", tag, " "}, id, 1'b0);
    end
    $display("rail reads done");
    send({"R", "VB1ff"});
    id = "01256789A";
    for (int i = 0; i < 9; i++) begin
      rd_one({"_R", "VB1 "}, {id.substr(i, i), "0"}, 1'b1);
    end
    $display("all bias read done");
    end_sim();
  end
endmodule : test_vch_handler
`default_nettype wire
